/* core/flkme_pkg.sv */
// constants, field layout and command codes of the flash lock and mode entry block
// assumes a single 10 MHz core clock shared by every file that imports it
`default_nettype none

package flkme_pkg;

  // array geometry
  localparam int NUM_REGIONS = 16;
  localparam int PAGES_PER_REGION = 32;
  localparam int PAGE_BYTES = 128;
  localparam int REGION_W = $clog2(NUM_REGIONS);
  localparam int PAGE_W = $clog2(NUM_REGIONS * PAGES_PER_REGION);
  localparam int CAL_W = 8;
  localparam logic [CAL_W-1:0] CAL_DEFAULT = 8'h5A;
  localparam logic [NUM_REGIONS-1:0] LOCK_RESET = 16'h0000;

  // timing, times in their own unit, counts derived from the clock rate
  localparam int CLK_KHZ = 10000;
  localparam int MS_PER_S = 1000;
  localparam int PROG_ERASE_MS = 6;
  localparam int PROG_ONLY_MS = 3;
  localparam int FULL_ERASE_MS = 15;
  localparam int RECOVERY_S = 10;
  localparam int PROG_ERASE_CYC = PROG_ERASE_MS * CLK_KHZ;
  localparam int PROG_ONLY_CYC = PROG_ONLY_MS * CLK_KHZ;
  localparam int FULL_ERASE_CYC = FULL_ERASE_MS * CLK_KHZ;
  localparam int RECOVERY_CYC = RECOVERY_S * MS_PER_S * CLK_KHZ;
  localparam int QUICK_CYC = 2;
  localparam int CNT_W = 27;

  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LOCK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CAL = 8'h10;

  // command word fields
  localparam int CMD_LSB = 0;
  localparam int CMD_W = 4;
  localparam int PAGE_LSB = 8;

  // status and mode layout; events share positions in both
  localparam int ST_READY = 0;
  localparam int EV_LSB = 1;
  localparam int EV_W = 2;
  localparam int EV_LOCK_ERR = 0;
  localparam int EV_DONE = 1;
  localparam int ST_FPM = 3;
  localparam int ST_RECOV = 4;
  localparam int ST_PROT = 5;
  localparam int ST_PAR = 6;

  typedef enum logic [CMD_W-1:0] {
    CMD_READ = 4'h0,
    CMD_PROG = 4'h1,
    CMD_PROG_NOERASE = 4'h2,
    CMD_PAGE_ERASE = 4'h3,
    CMD_FULL_ERASE = 4'h4,
    CMD_SET_LOCK = 4'h5,
    CMD_CLR_LOCK = 4'h6,
    CMD_PROTECT = 4'h7,
    CMD_RESTORE = 4'h8
  } flkme_cmd_e;

endpackage : flkme_pkg

`default_nettype wire

/* core/flkme_op_if.sv */
// handshake between the command sequencer and the operation timer
// assumes both ends run on core_clk
`default_nettype none

interface flkme_op_if;
  logic start;
  logic [flkme_pkg::CNT_W-1:0] cycles;
  logic busy;
  logic done;
  modport ctl (output start, output cycles, input busy, input done);
  modport tmr (input start, input cycles, output busy, output done);
endinterface : flkme_op_if

`default_nettype wire

/* core/flkme_op_timer.sv */
// operation timer: done pulses cycles cycles after start
// assumes cycles of at least 2 and a start only while idle
`default_nettype none

module flkme_op_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  flkme_op_if.tmr op
);
  import flkme_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic busy;
  logic done;

  assign op.busy = busy;
  assign op.done = done;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (op.start) begin
        cnt <= op.cycles - CNT_W'(1);
        busy <= 1'b1;
      end else if (busy && cnt == CNT_W'(1)) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - CNT_W'(1);
      end
    end
  end

  a_done_after_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
    done |-> $past(busy)) else $error("timer done without running");

endmodule : flkme_op_timer

`default_nettype wire

/* core/flkme_top.sv */
// flash lock protection, command sequencing and strap mode entry
// assumes straps, erase pin and programmer port are synchronous to core_clk
//
// Summary of operation
// - sixteen lock bits, each guarding one region of 32 pages of 128 bytes
// - program or erase to a locked region aborts, no flash change, sets lock error
// - lock error raises interrupt only when its enable bit is written one
// - set-lock command sets the addressed region's lock bit
// - clear-lock command clears the addressed region's lock bit
// - erase pin clears every lock bit
// - eight calibration bits are read only and survive the erase pin
// - test strap, mode straps zero and one high, two low: fast programming
// - fast programming accepts read, program, erase, lock, unlock, protect
// - programmer port serves serial or parallel source, each transfer acknowledged
// - all four straps high for ten seconds restores boot sectors, then halt
// - page program takes 6 ms with auto erase, 3 ms without
// - full erase completes in 15 ms and is then reported done
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`default_nettype none

module flkme_top #(
  parameter int PROG_ERASE_CYCLES = flkme_pkg::PROG_ERASE_CYC,
  parameter int PROG_ONLY_CYCLES = flkme_pkg::PROG_ONLY_CYC,
  parameter int FULL_ERASE_CYCLES = flkme_pkg::FULL_ERASE_CYC,
  parameter int RECOVERY_CYCLES = flkme_pkg::RECOVERY_CYC,
  parameter logic [flkme_pkg::CAL_W-1:0] CAL_VALUE = flkme_pkg::CAL_DEFAULT
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [flkme_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [flkme_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [flkme_pkg::DATA_W-1:0] reg_rdata,
  input wire logic erase_pin,
  input wire logic test_strap_pin,
  input wire logic mode_strap_zero,
  input wire logic mode_strap_one,
  input wire logic mode_strap_two,
  input wire logic pgm_valid,
  input wire logic pgm_parallel,
  input wire logic [flkme_pkg::CMD_W-1:0] pgm_cmd,
  input wire logic [flkme_pkg::PAGE_W-1:0] pgm_page,
  output logic pgm_ack,
  output logic flash_start,
  output logic flash_busy,
  output logic [flkme_pkg::CMD_W-1:0] flash_op,
  output logic [flkme_pkg::PAGE_W-1:0] flash_page,
  output logic [flkme_pkg::NUM_REGIONS-1:0] lock_state,
  output logic fast_prog_mode,
  output logic recovery_done,
  output logic irq
);
  import flkme_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RUN = 2'b01,
    S_RECOVER = 2'b10,
    S_HALT = 2'b11
  } flkme_state_e;

  localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(RECOVERY_CYCLES - 1);

  function automatic logic [REGION_W-1:0] region_of(input logic [PAGE_W-1:0] page);
    region_of = page[PAGE_W-1 -: REGION_W];
  endfunction : region_of

  function automatic logic touches_array(input logic [CMD_W-1:0] c);
    touches_array = (c == CMD_PROG) || (c == CMD_PROG_NOERASE) ||
                    (c == CMD_PAGE_ERASE) || (c == CMD_FULL_ERASE);
  endfunction : touches_array

  function automatic logic [CNT_W-1:0] op_len(input logic [CMD_W-1:0] c);
    case (c)
      CMD_PROG: op_len = CNT_W'(PROG_ERASE_CYCLES);
      CMD_PROG_NOERASE: op_len = CNT_W'(PROG_ONLY_CYCLES);
      CMD_PAGE_ERASE: op_len = CNT_W'(PROG_ONLY_CYCLES);
      CMD_FULL_ERASE: op_len = CNT_W'(FULL_ERASE_CYCLES);
      default: op_len = CNT_W'(QUICK_CYC);
    endcase
  endfunction : op_len

  // reset release through two flops
  logic [1:0] rst_pipe;
  logic rst_n;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  flkme_op_if op ();
  flkme_op_timer u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .op(op)
  );

  flkme_state_e state;
  flkme_state_e next_state;
  logic [CNT_W-1:0] rec_cnt;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] ev_ie;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic protect_bit;
  logic last_par;

  // strap decode
  logic fpm_pattern;
  logic rec_pattern;
  logic rec_fire;
  assign fpm_pattern = test_strap_pin & mode_strap_zero & mode_strap_one & ~mode_strap_two;
  assign rec_pattern = test_strap_pin & mode_strap_zero & mode_strap_one & mode_strap_two;
  assign rec_fire = rec_pattern && state == S_IDLE && rec_cnt == REC_LAST;

  // command take; programmer owns the flash in fast mode, so software is refused there
  logic sw_take;
  logic pgm_take;
  logic take;
  logic [CMD_W-1:0] take_cmd;
  logic [PAGE_W-1:0] take_page;
  logic [REGION_W-1:0] take_region;
  logic blocked;
  logic take_go;

  assign sw_take = reg_wr && reg_addr == OFF_CMD && state == S_IDLE &&
                   !fast_prog_mode && !rec_fire;
  assign pgm_take = pgm_valid && fast_prog_mode && state == S_IDLE &&
                    !pgm_ack && !rec_fire;
  assign take = sw_take || pgm_take;
  assign take_cmd = pgm_take ? pgm_cmd : reg_wdata[CMD_LSB +: CMD_W];
  assign take_page = pgm_take ? pgm_page : reg_wdata[PAGE_LSB +: PAGE_W];
  assign take_region = region_of(take_page);
  assign blocked = touches_array(take_cmd) &&
                   ((take_cmd == CMD_FULL_ERASE) ? (|lock_state) : lock_state[take_region]);
  assign take_go = take && !blocked;

  assign op.start = state == S_IDLE && (rec_fire || take_go);
  assign op.cycles = rec_fire ? CNT_W'(FULL_ERASE_CYCLES) : op_len(take_cmd);

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (rec_fire) begin
          next_state = S_RECOVER;
        end else if (take_go) begin
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        if (op.done) begin
          next_state = S_IDLE;
        end
      end
      S_RECOVER: begin
        if (op.done) begin
          next_state = S_HALT;
        end
      end
      S_HALT: next_state = S_HALT;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      flash_busy <= 1'b0;
    end else begin
      state <= next_state;
      flash_busy <= next_state == S_RUN || next_state == S_RECOVER;
    end
  end

  // straps are levels the programmer keeps; mode follows them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_prog_mode <= 1'b0;
    end else begin
      fast_prog_mode <= fpm_pattern;
    end
  end

  // a break in the pattern restarts the ten second count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_cnt <= '0;
    end else if (!rec_pattern || state != S_IDLE) begin
      rec_cnt <= '0;
    end else if (rec_cnt != REC_LAST) begin
      rec_cnt <= rec_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      recovery_done <= 1'b0;
    end else if (state == S_RECOVER && op.done) begin
      recovery_done <= 1'b1;
    end
  end

  // flash side strobe; aborted commands never reach it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_start <= 1'b0;
      flash_op <= CMD_READ;
      flash_page <= '0;
    end else begin
      flash_start <= op.start;
      if (op.start) begin
        flash_op <= rec_fire ? CMD_RESTORE : take_cmd;
        flash_page <= rec_fire ? '0 : take_page;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pgm_ack <= 1'b0;
      last_par <= 1'b0;
    end else begin
      pgm_ack <= pgm_take;
      if (pgm_take) begin
        last_par <= pgm_parallel;
      end
    end
  end

  // one lock bit per region; erase pin outranks commands
  for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_lock
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        lock_state[g] <= LOCK_RESET[g];
      end else if (erase_pin) begin
        lock_state[g] <= 1'b0;
      end else if (take_go && take_region == REGION_W'(g) && take_cmd == CMD_SET_LOCK) begin
        lock_state[g] <= 1'b1;
      end else if (take_go && take_region == REGION_W'(g) && take_cmd == CMD_CLR_LOCK) begin
        lock_state[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      protect_bit <= 1'b0;
    end else if (erase_pin) begin
      protect_bit <= 1'b0;
    end else if (take_go && take_cmd == CMD_PROTECT) begin
      protect_bit <= 1'b1;
    end
  end

  // sticky events, write one to clear, a new event wins over its clear
  always_comb begin
    ev_set = '0;
    ev_set[EV_LOCK_ERR] = take && blocked;
    ev_set[EV_DONE] = state == S_RUN && op.done;
    ev_clr = '0;
    if (reg_wr && reg_addr == OFF_STATUS) begin
      ev_clr = reg_wdata[EV_LSB +: EV_W];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev <= '0;
    end else begin
      ev <= (ev & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_ie <= '0;
    end else if (reg_wr && reg_addr == OFF_MODE) begin
      ev_ie <= reg_wdata[EV_LSB +: EV_W];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev & ev_ie);
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          OFF_MODE: reg_rdata[EV_LSB +: EV_W] <= ev_ie;
          OFF_STATUS: begin
            reg_rdata[ST_READY] <= state == S_IDLE;
            reg_rdata[EV_LSB +: EV_W] <= ev;
            reg_rdata[ST_FPM] <= fast_prog_mode;
            reg_rdata[ST_RECOV] <= recovery_done;
            reg_rdata[ST_PROT] <= protect_bit;
            reg_rdata[ST_PAR] <= last_par;
          end
          OFF_LOCK: reg_rdata[NUM_REGIONS-1:0] <= lock_state;
          OFF_CAL: reg_rdata[CAL_W-1:0] <= CAL_VALUE;
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // helper for duration checks
  logic [CNT_W-1:0] busy_len;
  logic [CNT_W-1:0] exp_len;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_len <= '0;
      exp_len <= '0;
    end else if (op.start) begin
      busy_len <= '0;
      exp_len <= op.cycles;
    end else if (flash_busy) begin
      busy_len <= busy_len + CNT_W'(1);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_locked_abort: assert property ((take && touches_array(take_cmd) &&
    take_cmd != CMD_FULL_ERASE && lock_state[region_of(take_page)]) |=>
    (ev[EV_LOCK_ERR] && !flash_start)) else $error("locked command not aborted");
  a_irq_gated: assert property ((ev_ie[EV_LOCK_ERR] == 1'b0 && !(ev[EV_DONE] && ev_ie[EV_DONE]))
    |=> !irq) else $error("interrupt without enable");
  a_set_lock: assert property ((take_go && take_cmd == CMD_SET_LOCK && !erase_pin) |=>
    lock_state[$past(take_region)]) else $error("set lock ignored");
  a_clear_lock: assert property ((take_go && take_cmd == CMD_CLR_LOCK && !erase_pin) |=>
    !lock_state[$past(take_region)]) else $error("clear lock ignored");
  a_erase_unlocks: assert property (erase_pin |=> lock_state == '0)
    else $error("erase pin left a lock set");
  a_cal_fixed: assert property ((reg_rd && reg_addr == OFF_CAL) |=>
    reg_rdata[CAL_W-1:0] == CAL_VALUE) else $error("calibration value changed");
  a_fpm_decode: assert property (##1 fast_prog_mode == $past(fpm_pattern))
    else $error("fast mode decode wrong");
  a_pgm_needs_fpm: assert property (pgm_ack |-> $past(fast_prog_mode) && $past(pgm_valid))
    else $error("programmer served outside fast mode");
  a_recovery_entry: assert property ($rose(state == S_RECOVER) |->
    $past(rec_cnt) == REC_LAST && $past(rec_pattern)) else $error("early recovery");
  a_prog_length: assert property ((op.start && !rec_fire && take_cmd == CMD_PROG) |=>
    exp_len == CNT_W'(PROG_ERASE_CYCLES)) else $error("program time wrong");
  a_op_duration: assert property ($fell(flash_busy) |-> busy_len == exp_len)
    else $error("busy length differs from operation time");

  c_lock_abort: cover property (take && blocked);
  c_full_erase: cover property ($fell(flash_busy) && exp_len == CNT_W'(FULL_ERASE_CYCLES));
  c_pgm_cmd: cover property (pgm_ack);
  c_irq: cover property (irq);

endmodule : flkme_top

`default_nettype wire

/* bench/flkme_pgm_model.sv */
// programmer partner model: drives the fast programming command port
// assumes the bench sets the straps and core_clk runs free
`default_nettype none

module flkme_pgm_model (
  input wire logic core_clk,
  input wire logic pgm_ack,
  output var logic pgm_valid,
  output var logic pgm_parallel,
  output var logic [flkme_pkg::CMD_W-1:0] pgm_cmd,
  output var logic [flkme_pkg::PAGE_W-1:0] pgm_page
);
  timeunit 1ns;
  timeprecision 1ns;
  import flkme_pkg::*;

  initial begin
    pgm_valid = 1'b0;
    pgm_parallel = 1'b0;
    pgm_cmd = 4'h0;
    pgm_page = 9'h000;
  end

  // request held until ack is sampled or 80 edges pass; released lines show the inverse
  task automatic send(input logic [CMD_W-1:0] cmd, input logic [PAGE_W-1:0] page,
                      input logic par, input int stall, output logic ok);
    int i;
    repeat (stall) @(posedge core_clk);
    pgm_cmd <= cmd;
    pgm_page <= page;
    pgm_parallel <= par;
    pgm_valid <= 1'b1;
    ok = 1'b0;
    for (i = 0; i < 80 && ok !== 1'b1; i++) begin
      @(posedge core_clk);
      if (pgm_ack === 1'b1) ok = 1'b1;
    end
    pgm_valid <= 1'b0;
    pgm_cmd <= ~cmd;
    pgm_page <= ~page;
    pgm_parallel <= ~par;
    @(posedge core_clk);
  endtask : send
endmodule : flkme_pgm_model

`default_nettype wire

/* bench/flkme_top_tb.sv */
// self-checking bench for the flash lock and mode entry block
// assumes short cycle counts by parameter; straps and registers driven here
`default_nettype none

module flkme_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import flkme_pkg::*;

  // short counts keep the run small; expectations follow them
  localparam int PE = 20;
  localparam int PO = 10;
  localparam int FE = 30;
  localparam int RC = 50;

  logic core_clk = 1'b0;
  logic nrst, reg_wr, reg_rd, erase_pin, tst, m0, m1, m2, ok;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic pgm_valid, pgm_parallel, pgm_ack, flash_start, flash_busy;
  logic fast_prog_mode, recovery_done, irq;
  logic [CMD_W-1:0] pgm_cmd, flash_op;
  logic [PAGE_W-1:0] pgm_page, flash_page, pg;
  logic [NUM_REGIONS-1:0] lock_state, exp_lock;
  logic [15:0] seed = 16'h0277;
  int err_count = 0;
  int tests_run = 0;
  int starts = 0;
  int n, k, s0;

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (flash_start === 1'b1) starts <= starts + 1;

  flkme_top #(.PROG_ERASE_CYCLES(PE), .PROG_ONLY_CYCLES(PO), .FULL_ERASE_CYCLES(FE),
    .RECOVERY_CYCLES(RC)) dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .erase_pin(erase_pin), .test_strap_pin(tst), .mode_strap_zero(m0),
    .mode_strap_one(m1), .mode_strap_two(m2), .pgm_valid(pgm_valid),
    .pgm_parallel(pgm_parallel), .pgm_cmd(pgm_cmd), .pgm_page(pgm_page),
    .pgm_ack(pgm_ack), .flash_start(flash_start), .flash_busy(flash_busy),
    .flash_op(flash_op), .flash_page(flash_page), .lock_state(lock_state),
    .fast_prog_mode(fast_prog_mode), .recovery_done(recovery_done), .irq(irq));

  flkme_pgm_model pgm (.core_clk(core_clk), .pgm_ack(pgm_ack), .pgm_valid(pgm_valid),
    .pgm_parallel(pgm_parallel), .pgm_cmd(pgm_cmd), .pgm_page(pgm_page));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic int exp_len(input logic [CMD_W-1:0] c);
    case (c)
      CMD_PROG: return PE;
      CMD_PROG_NOERASE, CMD_PAGE_ERASE: return PO;
      CMD_FULL_ERASE: return FE;
      default: return 2;
    endcase
  endfunction : exp_len

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    // back to back writes: let the previous strobe drop for one edge first
    if (reg_wr === 1'b1) @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
    check(d, e);
  endtask : rd_chk

  // waits are bounded; a hang ends the run as a mismatch
  task automatic wait_idle(output int len);
    len = 0;
    for (int i = 0; i < 200; i++) begin
      @(posedge core_clk);
      if (flash_busy !== 1'b1) begin
        @(posedge core_clk);
        return;
      end
      len++;
    end
    err_count++;
    wrap_up();
  endtask : wait_idle

  task automatic run(input logic [CMD_W-1:0] c, input logic [PAGE_W-1:0] p, output int len);
    wr(OFF_CMD, {15'h0000, p, 4'h0, c});
    wait_idle(len);
  endtask : run

  initial begin
    {nrst, reg_wr, reg_rd, erase_pin, tst, m0, m1, m2} = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    exp_lock = LOCK_RESET;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_chk(OFF_LOCK, 32'h0);
    rd_chk(OFF_CAL, 32'(CAL_DEFAULT));
    rd_chk(8'h14, 32'h0);
    rd_chk(OFF_STATUS, 32'h1);
    // lock regions, boundary pages first, then random ones
    for (k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      pg = (k == 0) ? 9'h000 : (k == 1) ? 9'h1FF : seed[8:0];
      run(CMD_SET_LOCK, pg, n);
      exp_lock[pg[8:5]] = 1'b1;
      rd_chk(OFF_LOCK, 32'(exp_lock));
      check(32'(lock_state), 32'(exp_lock));
    end
    wr(OFF_STATUS, 32'h6);
    wr(OFF_MODE, 32'h2);
    s0 = starts;
    run(CMD_PROG, pg, n);
    check(32'(n), 32'h0);
    rd_chk(OFF_STATUS, 32'h3);
    check(32'(irq), 32'h1);
    wr(OFF_STATUS, 32'h2);
    rd_chk(OFF_STATUS, 32'h1);
    check(32'(irq), 32'h0);
    wr(OFF_MODE, 32'h0);
    run(CMD_PAGE_ERASE, pg, n);
    run(CMD_FULL_ERASE, 9'h000, n);
    rd_chk(OFF_STATUS, 32'h3);
    check(32'(irq), 32'h0);
    check(32'(starts - s0), 32'h0);
    run(CMD_CLR_LOCK, pg, n);
    run(CMD_PROG, pg, n);
    check(32'(n), 32'(PE));
    check(32'(starts - s0), 32'h2);
    for (k = 0; k < NUM_REGIONS; k++) run(CMD_CLR_LOCK, 9'(k * PAGES_PER_REGION), n);
    check(32'(lock_state), 32'h0);
    // operation lengths, each ending with the done event
    for (k = 1; k < 5; k++) begin
      wr(OFF_STATUS, 32'h6);
      seed = lfsr(seed);
      run(4'(k), seed[8:0], n);
      check(32'(n), 32'(exp_len(4'(k))));
      rd_chk(OFF_STATUS, 32'h5);
    end
    run(CMD_SET_LOCK, 9'h0A0, n);
    run(CMD_SET_LOCK, 9'h1E0, n);
    erase_pin <= 1'b1;
    wr(OFF_CAL, 32'h000000A5);
    erase_pin <= 1'b0;
    rd_chk(OFF_CAL, 32'(CAL_DEFAULT));
    check(32'(lock_state), 32'h0);
    // straps: wrong pattern is refused, right one enters fast mode
    {tst, m0, m1, m2} <= 4'b1100;
    repeat (3) @(posedge core_clk);
    check(32'(fast_prog_mode), 32'h0);
    pgm.send(CMD_READ, 9'h000, 1'b0, 0, ok);
    check(32'(ok), 32'h0);
    {tst, m0, m1, m2} <= 4'b1110;
    repeat (3) @(posedge core_clk);
    check(32'(fast_prog_mode), 32'h1);
    seed = lfsr(seed);
    pg = seed[8:0];
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      pgm.send(4'(k), pg, seed[9], 32'(seed[1:0]), ok);
      check(32'(ok), 32'h1);
      check(32'(flash_op), 32'(k));
      check(32'(flash_page), 32'(pg));
      wait_idle(n);
      rd_chk(OFF_STATUS, 32'h0D | (32'(k == 7) << ST_PROT) | (32'(seed[9]) << ST_PAR));
      check(32'(d[ST_PAR]), 32'(seed[9]));
      if (k == 5) check(32'(lock_state[pg[8:5]]), 32'h1);
    end
    check(32'(lock_state), 32'h0);
    check(32'(d[ST_PROT]), 32'h1);
    // boot restore after the hold time, then the block halts
    {tst, m0, m1, m2} <= 4'b1111;
    for (n = 0; n < 400 && recovery_done !== 1'b1; n++) @(posedge core_clk);
    check(32'(n >= RC + FE && n <= RC + FE + 8), 32'h1);
    check(32'(flash_op), 32'(CMD_RESTORE));
    check(32'(fast_prog_mode), 32'h0);
    {tst, m0, m1, m2} <= 4'b0000;
    wr(OFF_CMD, {24'h000000, 4'h0, CMD_SET_LOCK});
    repeat (4) @(posedge core_clk);
    check(32'(lock_state), 32'h0);
    // only a reset leaves the halt
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(32'(recovery_done), 32'h0);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    run(CMD_SET_LOCK, 9'h020, n);
    check(32'(lock_state), 32'h0002);
    wrap_up();
  end
endmodule : flkme_top_tb

`default_nettype wire
